// ==== core/mpb_defs.vh ====
// Behaviour
// [R1] pins whose names end in _n are asserted low; every other signal is asserted high.
// [R2] buffer_direction_n steers the external transceiver: high passes data out, low passes data in.
// [R3] buffer_output_enable_n opens the transceiver only while a transfer uses the data lines.
// [R4] the write strobe is asserted during write transfers.
// [R5] four active-low device selects, each picking one external device for the transaction.
// [R6] a 22-bit address sits on dedicated pins; bits 25 to 22 appear only on pins switched to address use.
// [R7] the 8-bit data bus carries transfer data, and during cold reset it is sampled as the boot vector.
// [R8] the read output strobe is asserted while the selected device is expected to drive data.
// [R9] read_not_write is high for the whole of a read and low for the whole of a write.
// [R10] in wait mode the external device holds the cycle open while it asserts wait_or_acknowledge_n.
// [R11] in acknowledge mode the transaction ends only after wait_or_acknowledge_n is seen asserted.
// [R12] general-purpose pins 4 to 7 carry address bits 22 to 25 when switched to their alternate function.
// [R13] at most one select per transaction, and address, direction and select stay stable until it ends.
// [R14] wait or acknowledge behaviour is chosen per device select.
`ifndef MPB_DEFS_VH
`define MPB_DEFS_VH
`define MPB_ADDR_W       26
`define MPB_PIN_ADDR_W   22
`define MPB_HI_ADDR_W    4
`define MPB_DATA_W       8
`define MPB_NSEL         4
`define MPB_WS_W         6
`define MPB_SEL_IDLE     4'hF
`define MPB_DATA_ZERO    8'h00
`define MPB_WS_ZERO      6'h00
`define MPB_WS_ONE       6'h01
// the wait pin reaches the logic two edges late, so its first two samples in a cycle are stale
`define MPB_SETTLE_FULL  2'h3
`define MPB_SETTLE_ZERO  2'h0
`define MPB_GPIO_ZERO    4'h0
`endif

// ==== core/mpb_port.v ====
`timescale 1ns/1ps
`include "mpb_defs.vh"
module mpb_port
#(
    parameter WS_W = `MPB_WS_W
)
(
    // clock, enable, resets
    input  wire                        clk,
    input  wire                        rst,
    input  wire                        ce,
    input  wire                        cold_reset,
    // configuration
    input  wire [`MPB_NSEL-1:0]        sel_ack_mode,
    input  wire [WS_W-1:0]             wait_states,
    input  wire [`MPB_HI_ADDR_W-1:0]   gpio_alt_en,
    input  wire [`MPB_HI_ADDR_W-1:0]   gpio_out,
    input  wire [`MPB_HI_ADDR_W-1:0]   gpio_oe,
    // request side
    input  wire                        req_valid,
    input  wire                        req_read,
    input  wire [1:0]                  req_sel,
    input  wire [`MPB_ADDR_W-1:0]      req_addr,
    input  wire [`MPB_DATA_W-1:0]      req_wdata,
    output reg                         req_ready,
    output reg                         rsp_valid,
    output reg  [`MPB_DATA_W-1:0]      rsp_rdata,
    output reg  [`MPB_DATA_W-1:0]      boot_vector,
    output reg                         boot_vector_valid,
    // external bus
    output reg                         buffer_direction_n,
    output reg                         buffer_output_enable_n,
    output reg                         write_strobe_n,
    output reg  [`MPB_NSEL-1:0]        device_selects_n,
    output reg  [`MPB_PIN_ADDR_W-1:0]  periph_address,
    output reg                         read_output_strobe_n,
    output reg                         read_not_write,
    input  wire [`MPB_DATA_W-1:0]      periph_data_in,
    output reg  [`MPB_DATA_W-1:0]      periph_data_out,
    output reg  [`MPB_DATA_W-1:0]      periph_data_oe_n,
    input  wire                        wait_or_acknowledge_n,
    // general-purpose pins 4..7
    input  wire [`MPB_HI_ADDR_W-1:0]   gpio_in,
    output reg  [`MPB_HI_ADDR_W-1:0]   gpio_pin_out,
    output reg  [`MPB_HI_ADDR_W-1:0]   gpio_pin_oe_n,
    output reg  [`MPB_HI_ADDR_W-1:0]   gpio_in_value
);
    localparam S_IDLE = 3'b001;
    localparam S_ACT  = 3'b010;
    localparam S_DONE = 3'b100;

    reg  [2:0]                 state_q;
    reg  [WS_W-1:0]            ws_q;
    reg  [1:0]                 settle_q;
    reg                        ack_mode_q;
    reg  [`MPB_HI_ADDR_W-1:0]  hi_addr_q;
    reg                        cold_q;
    wire [`MPB_DATA_W-1:0]     data_s;
    wire                       wack_s;
    wire                       cold_s;
    wire [`MPB_HI_ADDR_W-1:0]  gpio_s;

    function [`MPB_NSEL-1:0] sel_decode;
        input [1:0] idx;
        begin
            sel_decode = ~(4'h1 << idx);
        end
    endfunction

    mpb_sync #(.W(`MPB_DATA_W), .RST_V(0)) u_dsync
    (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (periph_data_in),
        .dout (data_s)
    );
    mpb_sync #(.W(1), .RST_V(1)) u_wsync
    (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (wait_or_acknowledge_n),
        .dout (wack_s)
    );
    mpb_sync #(.W(1), .RST_V(1)) u_csync
    (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (cold_reset),
        .dout (cold_s)
    );
    mpb_sync #(.W(`MPB_HI_ADDR_W), .RST_V(0)) u_gsync
    (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .din  (gpio_in),
        .dout (gpio_s)
    );

    // pins 4..7: address bits 22..25 in alternate mode, else plain gpio
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gpio_pin_out  <= `MPB_GPIO_ZERO;
            gpio_pin_oe_n <= ~`MPB_GPIO_ZERO;
            gpio_in_value <= `MPB_GPIO_ZERO;
        end
        else if (ce)
        begin
            gpio_pin_out  <= (gpio_alt_en & hi_addr_q) | (~gpio_alt_en & gpio_out);  // [R12] [R6]
            gpio_pin_oe_n <= ~(gpio_alt_en | gpio_oe);                               // [R12]
            gpio_in_value <= gpio_s;
        end
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q                <= S_IDLE;
            ws_q                   <= `MPB_WS_ZERO;
            settle_q               <= `MPB_SETTLE_ZERO;
            ack_mode_q             <= 1'b0;
            hi_addr_q              <= `MPB_GPIO_ZERO;
            cold_q                 <= 1'b0;
            req_ready              <= 1'b0;
            rsp_valid              <= 1'b0;
            rsp_rdata              <= `MPB_DATA_ZERO;
            boot_vector            <= `MPB_DATA_ZERO;
            boot_vector_valid      <= 1'b0;
            buffer_direction_n     <= 1'b0;
            buffer_output_enable_n <= 1'b1;
            write_strobe_n         <= 1'b1;
            device_selects_n       <= `MPB_SEL_IDLE;
            periph_address         <= {`MPB_PIN_ADDR_W{1'b0}};
            read_output_strobe_n   <= 1'b1;
            read_not_write         <= 1'b1;
            periph_data_out        <= `MPB_DATA_ZERO;
            periph_data_oe_n       <= ~`MPB_DATA_ZERO;
        end
        else if (ce)
        begin
            cold_q    <= cold_s;
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            if (cold_s)
            begin
                // data pins are inputs; vector taken on the last sample before release
                periph_data_oe_n  <= ~`MPB_DATA_ZERO;       // [R7]
                boot_vector       <= data_s;                // [R7]
                boot_vector_valid <= 1'b0;
                state_q           <= S_IDLE;
                device_selects_n  <= `MPB_SEL_IDLE;
                buffer_output_enable_n <= 1'b1;
                read_output_strobe_n   <= 1'b1;
                write_strobe_n         <= 1'b1;
            end
            else
            begin
                if (cold_q)
                    boot_vector_valid <= 1'b1;
                case (state_q)
                    S_IDLE:
                    begin
                        req_ready <= 1'b1;
                        if (req_valid && req_ready)
                        begin
                            req_ready              <= 1'b0;
                            periph_address         <= req_addr[`MPB_PIN_ADDR_W-1:0];              // [R6] [R13]
                            hi_addr_q              <= req_addr[`MPB_ADDR_W-1:`MPB_PIN_ADDR_W];    // [R6]
                            device_selects_n       <= sel_decode(req_sel);                        // [R5] [R13] [R1]
                            ack_mode_q             <= sel_ack_mode[req_sel];                      // [R14]
                            read_not_write         <= req_read;                                   // [R9]
                            buffer_direction_n     <= ~req_read;                                  // [R2]
                            buffer_output_enable_n <= 1'b0;                                       // [R3]
                            read_output_strobe_n   <= ~req_read;                                  // [R8]
                            write_strobe_n         <= req_read;                                   // [R4]
                            periph_data_out        <= req_wdata;
                            periph_data_oe_n       <= {`MPB_DATA_W{req_read}};                    // [R7]
                            ws_q                   <= wait_states;
                            settle_q               <= `MPB_SETTLE_FULL;
                            state_q                <= S_ACT;
                        end
                    end
                    S_ACT:
                    begin
                        // without this a zero wait-state cycle in wait mode would end on the idle pin level
                        settle_q <= settle_q >> 1;
                        if (ws_q != `MPB_WS_ZERO)
                            ws_q <= ws_q - `MPB_WS_ONE;
                        else if (settle_q == `MPB_SETTLE_ZERO && (ack_mode_q ? !wack_s : wack_s))   // [R10] [R11]
                        begin
                            rsp_rdata              <= data_s;
                            rsp_valid              <= read_not_write;
                            device_selects_n       <= `MPB_SEL_IDLE;
                            read_output_strobe_n   <= 1'b1;
                            write_strobe_n         <= 1'b1;
                            buffer_output_enable_n <= 1'b1;       // [R3]
                            state_q                <= S_DONE;
                        end
                    end
                    S_DONE:
                    begin
                        // one turnaround cycle before data pins or direction change
                        periph_data_oe_n <= ~`MPB_DATA_ZERO;
                        if (!read_not_write)
                            rsp_valid <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    default:
                        state_q <= S_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== core/mpb_sync.v ====
`timescale 1ns/1ps
`include "mpb_defs.vh"
// two-stage synchroniser for pin inputs; the first stage feeds only the second
module mpb_sync
#(
    parameter W     = 1,
    parameter RST_V = 0
)
(
    // clock and reset
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    // data
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= {W{RST_V[0]}};
            dout   <= {W{RST_V[0]}};
        end
        else if (ce)
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// ==== sim/memory_peripheral_bus_port_tb_top.sv ====
`timescale 1ns/1ps
module memory_peripheral_bus_port_tb_top;
    logic        clk, rst, ce, cold_reset, req_valid, req_read, strap_en, req_ready, rsp_valid, boot_vector_valid;
    logic        buffer_direction_n, buffer_output_enable_n, write_strobe_n, read_output_strobe_n, read_not_write;
    logic        wait_or_acknowledge_n;
    logic [1:0]  req_sel;
    logic [3:0]  sel_ack_mode, gpio_alt_en, gpio_out, gpio_oe, gpio_in, device_selects_n, gpio_pin_out, gpio_pin_oe_n;
    logic [3:0]  gpio_in_value;
    logic [5:0]  wait_states, dly;
    logic [7:0]  req_wdata, rsp_rdata, boot_vector, periph_data_in, periph_data_out, periph_data_oe_n;
    logic [21:0] periph_address;
    logic [25:0] req_addr;
    int          err_total, total_checks, n;
    always #25 clk = ~clk;
    mpb_port i_mpb_port (.clk, .rst, .ce, .cold_reset, .sel_ack_mode, .wait_states, .gpio_alt_en, .gpio_out, .gpio_oe,
        .req_valid, .req_read, .req_sel, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .boot_vector,
        .boot_vector_valid, .buffer_direction_n, .buffer_output_enable_n, .write_strobe_n, .device_selects_n,
        .periph_address, .read_output_strobe_n, .read_not_write, .periph_data_in, .periph_data_out,
        .periph_data_oe_n, .wait_or_acknowledge_n, .gpio_in, .gpio_pin_out, .gpio_pin_oe_n, .gpio_in_value);
    mpb_dev_model i_mpb_dev_model (.clk, .rst, .dly, .sel_ack_mode, .strap_en, .device_selects_n, .periph_address,
        .read_output_strobe_n, .write_strobe_n, .periph_data_out, .periph_data_oe_n, .periph_data_in,
        .wait_or_acknowledge_n);
    task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one transfer; pins are judged on the second cycle a select is low, when the gpio copy has caught up
    task automatic xfer(input logic r, input logic [1:0] s, input logic [25:0] a, input logic [7:0] w);
        {req_valid, req_read, req_sel, req_addr, req_wdata} <= {1'b1, r, s, a, w};
        n = 0;
        do @(posedge clk); while (req_ready !== 1'b1 && n++ < 50);
        req_valid <= 1'b0;
        do @(posedge clk); while (device_selects_n === 4'hF && n++ < 50);
        @(posedge clk);
        chk("bus", {device_selects_n, periph_address, read_not_write, buffer_direction_n, buffer_output_enable_n},
            {~(4'h1 << s), a[21:0], r, !r, 1'b0});
        chk("strobes", {read_output_strobe_n, write_strobe_n, periph_data_oe_n, gpio_pin_out & gpio_alt_en},
            {!r, r, {8{r}}, a[25:22] & gpio_alt_en});
        n = 0;
        while (device_selects_n !== 4'hF && n++ < 200) @(posedge clk);
        chk("held", n > dly, 1'b1);
        while (rsp_valid !== 1'b1 && n++ < 250) @(posedge clk);
        chk("done", rsp_valid, 1'b1);
    endtask
    task automatic t_wait;
        xfer(1'b0, 2'h1, 26'h012_3456, 8'hA5);
        xfer(1'b0, 2'h1, 26'h012_3457, 8'h5A);
        xfer(1'b1, 2'h1, 26'h012_3456, 8'h00);
        chk("read", rsp_rdata, 8'hA5);
        dly <= 6'h00;
        xfer(1'b1, 2'h0, 26'h000_0007, 8'h00);
        chk("read", rsp_rdata, 8'h5A);
        // no programmed wait states: only the pin stretches this read
        {wait_states, dly} <= {6'h00, 6'h02};
        xfer(1'b1, 2'h0, 26'h000_0006, 8'h00);
        chk("read", rsp_rdata, 8'hA5);
    endtask
    // select 2 acknowledges, select 3 waits; high address bits ride the pins
    task automatic t_ack;
        sel_ack_mode <= 4'h4;
        gpio_alt_en  <= 4'hF;
        dly          <= 6'h03;
        xfer(1'b0, 2'h2, 26'h2C0_000C, 8'hC3);
        gpio_alt_en <= 4'h5;
        xfer(1'b1, 2'h3, 26'h1C0_000C, 8'h00);
        chk("read", rsp_rdata, 8'hC3);
    endtask
    task automatic t_pins;
        {gpio_alt_en, gpio_out, gpio_oe, gpio_in} <= 16'h0956;
        repeat (5) @(posedge clk);
        chk("gpio", {gpio_pin_out, gpio_pin_oe_n, gpio_in_value}, {4'h9, 4'hA, 4'h6});
        // with the enable low the pins keep their last value
        {ce, gpio_out} <= {1'b0, 4'h6};
        repeat (3) @(posedge clk);
        chk("frozen", gpio_pin_out, 4'h9);
        {ce, cold_reset, strap_en} <= 3'b111;
        repeat (10) @(posedge clk);
        chk("refused", {req_ready, boot_vector_valid, periph_data_oe_n}, {1'b0, 1'b0, 8'hFF});
        cold_reset <= 1'b0;
        repeat (8) @(posedge clk);
        strap_en <= 1'b0;
        chk("boot", {boot_vector_valid, boot_vector}, {1'b1, 8'h3C});
        xfer(1'b1, 2'h1, 26'h012_3457, 8'h00);
        chk("read", rsp_rdata, 8'h5A);
    endtask
    initial
    begin
        {clk, rst, ce, cold_reset, req_valid, req_read, strap_en, req_sel} = 9'h0C0;
        {sel_ack_mode, gpio_alt_en, gpio_out, gpio_oe, gpio_in, wait_states, dly} = 32'h0000_00C5;
        {req_addr, req_wdata} = 34'h0_0000_0000;
        repeat (15) @(posedge clk);
        chk("reset", {device_selects_n, read_output_strobe_n, write_strobe_n, buffer_output_enable_n,
            read_not_write, periph_data_oe_n, req_ready}, {4'hF, 4'hF, 8'hFF, 1'b0});
        @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_wait;
        t_ack;
        t_pins;
        results;
    end
    // far beyond the longest sequence; a hang ends the run as a mismatch
    initial
    begin
        #200000;
        err_total++;
        results;
    end
endmodule

// ==== sim/mpb_dev_model.sv ====
`timescale 1ns/1ps
module mpb_dev_model
(
    // bench controls
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [5:0]  dly,
    input  wire logic [3:0]  sel_ack_mode,
    input  wire logic        strap_en,
    // bus pins
    input  wire logic [3:0]  device_selects_n,
    input  wire logic [21:0] periph_address,
    input  wire logic        read_output_strobe_n,
    input  wire logic        write_strobe_n,
    input  wire logic [7:0]  periph_data_out,
    input  wire logic [7:0]  periph_data_oe_n,
    output wire logic [7:0]  periph_data_in,
    output wire logic        wait_or_acknowledge_n
);
    logic [7:0] mem [0:15];
    logic [7:0] junk;
    logic [5:0] cnt;
    wire        act  = device_selects_n != 4'hF;
    wire        ackm = |(sel_ack_mode & ~device_selects_n);
    // an undriven bus toggles every cycle so a stale byte never passes as read data
    assign periph_data_in = !read_output_strobe_n ? mem[periph_address[3:0]] : strap_en ? 8'h3C : junk;
    // pull-up when idle; wait mode holds low dly cycles, acknowledge mode goes low after dly
    assign wait_or_acknowledge_n = !act | (ackm ? cnt < dly : cnt >= dly);
    always @(posedge clk or posedge rst)
        if (rst)
            {cnt, junk} <= 14'h0000;
        else
        begin
            junk <= ~junk;
            cnt  <= act ? cnt + 6'h01 : 6'h00;
            if (act && !write_strobe_n && periph_data_oe_n == 8'h00)
                mem[periph_address[3:0]] <= periph_data_out;
        end
endmodule

// ==== sim/mpb_port_asserts.sv ====
`timescale 1ns/1ps
module mpb_port_asserts
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // request side and bus pins
    input wire logic [3:0]  sel_ack_mode,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [1:0]  req_sel,
    input wire logic        buffer_direction_n,
    input wire logic        buffer_output_enable_n,
    input wire logic        write_strobe_n,
    input wire logic [3:0]  device_selects_n,
    input wire logic [21:0] periph_address,
    input wire logic        read_output_strobe_n,
    input wire logic        read_not_write,
    input wire logic        wait_or_acknowledge_n
);
    wire act  = device_selects_n != 4'hF;
    wire ackm = |(sel_ack_mode & ~device_selects_n);
    wire wl   = !wait_or_acknowledge_n;
    wire [26:0] cyc = {periph_address, read_not_write, device_selects_n};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sel_one_a: assert property (!act || $onehot(~device_selects_n)) else $error("two selects");
    sel_start_a: assert property (req_valid && req_ready |=> device_selects_n == ~(4'h1 << $past(req_sel)))
        else $error("wrong select");
    rd_level_a: assert property (!read_output_strobe_n |-> act && read_not_write) else $error("read strobe");
    wr_level_a: assert property (!write_strobe_n |-> act && !read_not_write) else $error("write strobe");
    xcvr_ctrl_a: assert property (act |-> !buffer_output_enable_n && buffer_direction_n == !read_not_write)
        else $error("transceiver control");
    cycle_hold_a: assert property (act && $past(act) |-> $stable(cyc))
        else $error("cycle unstable");
    wait_hold_a: assert property (act && !ackm && wl && $past(wl) && $past(wl, 2) |=> act)
        else $error("wait ignored");
    ack_hold_a: assert property (act && ackm && !wl && !$past(wl) && !$past(wl, 2) |=> act)
        else $error("ended early");
    cover property (!read_output_strobe_n);
    cover property (!write_strobe_n && ackm);
    cover property (act && !ackm && wl);
endmodule
bind mpb_port mpb_port_asserts i_mpb_port_asserts (.clk, .rst, .sel_ack_mode, .req_valid, .req_ready, .req_sel,
    .buffer_direction_n, .buffer_output_enable_n, .write_strobe_n, .device_selects_n, .periph_address,
    .read_output_strobe_n, .read_not_write, .wait_or_acknowledge_n);
